// [smbx_pkg.sv]
// Purpose: shared constants and types for the smbus alert/timeout/general call block
// Assumes: 200 MHz system clock, bus pins sampled synchronously
// Notes:   timing counts derive from times in their own units
package smbx_pkg;
  localparam int unsigned CLK_MHZ         = 200;                     // system clock rate
  localparam int unsigned TOUT_MIN_MS     = 25;                      // least clock-low timeout
  localparam int unsigned TOUT_MAX_MS     = 75;                      // longest clock-low timeout
  localparam int unsigned TOUT_USE_MS     = 30;                      // chosen threshold inside window
  localparam int unsigned TOUT_CYC        = TOUT_USE_MS * 1000 * CLK_MHZ; // threshold in cycles
  localparam int unsigned TPOR_US         = 500;                     // longest busy time
  localparam int unsigned COPY_US         = 200;                     // copy time used
  localparam int unsigned COPY_CYC        = COPY_US * CLK_MHZ;       // copy busy cycles
  localparam logic [7:0]  ARA_BYTE        = 8'h19;                   // alert response address byte
  localparam logic [6:0]  GCALL_ADDR      = 7'h00;                   // general call address
  localparam logic [7:0]  GC_RELATCH      = 8'h04;                   // re-latch address command
  localparam logic [7:0]  GC_RESET        = 8'h06;                   // general call reset command
  localparam logic [3:0]  DEV_ADDR_HI     = 4'h9;                    // fixed upper address bits 1001
  localparam logic [2:0]  STRAP_RST       = 3'h0;                    // strap latch value at reset
  // serial engine states
  typedef enum logic [2:0] {
    SMBX_IDLE  = 3'b000,
    SMBX_ADDR  = 3'b001,
    SMBX_AACK  = 3'b010,
    SMBX_TXB   = 3'b011,
    SMBX_TXACK = 3'b100,
    SMBX_CMD   = 3'b101,
    SMBX_CACK  = 3'b110,
    SMBX_WAIT  = 3'b111
  } smbx_state_e;
  // alert configuration bits
  typedef struct packed {
    logic thermostat_irq_mode; // interrupt mode when one
    logic alert_polarity;      // zero selects active low
  } smbx_cfg_s;
endpackage : smbx_pkg

// [smbx_top.sv]
// Purpose: smbus alert response, bus timeout and general call slave logic
// Assumes: scl/sda inputs synchronous to clk; open-drain outputs, oe low drives low
// Notes:   copy engine only signals a request; register storage lives elsewhere
`timescale 1ns/1ps
module smbx_top
  import smbx_pkg::*;
#(
  parameter int unsigned TOUT_CYCLES = TOUT_CYC, // clock-low timeout in cycles
  parameter int unsigned COPY_CYCLES = COPY_CYC  // register copy busy cycles
) (
  input  wire logic              clk,             // system clock
  input  wire logic              rst_n,           // async reset, active low
  input  wire logic              scl_i,           // bus clock level
  input  wire logic              sda_i,           // bus data level
  output logic                   sda_oe_n,        // low pulls sda low
  output logic                   alert_oe_n,      // low pulls alert low
  input  wire smbx_pkg::smbx_cfg_s cfg,           // mode and polarity bits
  input  wire logic              alarm_set,       // pulse, limit tripped
  input  wire logic              alarm_high,      // one for high limit event
  input  wire logic [2:0]        addr_strap_pins, // address strap levels
  output logic [2:0]             strap_addr,      // latched strap address
  output logic                   copy_busy,       // nonvolatile copy running
  output logic                   copy_start,      // pulse, start copy
  output logic                   bus_timeout      // pulse, timeout fired
);
  import smbx_pkg::*;

  // sampled bus lines for edge detection
  logic scl_q_ff, sda_q_ff;
  logic nxt_scl_q, nxt_sda_q;
  // engine state
  smbx_state_e st_ff, nxt_st;
  logic [7:0]  sh_ff, nxt_sh;         // shift register
  logic [3:0]  bit_ff, nxt_bit;       // bit counter
  logic        sda_ff, nxt_sda;       // drive low when zero
  logic        alert_ff, nxt_alert;   // pending alert
  logic        lim_ff, nxt_lim;       // limit bit
  logic [2:0]  strap_ff, nxt_strap;   // latched strap
  logic [31:0] tcnt_ff, nxt_tcnt;     // clock-low counter
  logic [31:0] ccnt_ff, nxt_ccnt;     // copy busy counter
  logic        busy_ff, nxt_busy;
  logic        cst_ff, nxt_cst;
  logic        tof_ff, nxt_tof;
  logic        ara_ff, nxt_ara;       // ara response in progress

  wire scl_rise = scl_i & ~scl_q_ff;  // clock rising, sample data
  wire scl_fall = ~scl_i & scl_q_ff;  // clock falling, change data
  wire start_c  = scl_i & scl_q_ff & sda_q_ff & ~sda_i; // start or repeated start
  wire stop_c   = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  wire alert_en = cfg.thermostat_irq_mode & ~cfg.alert_polarity;
  wire [7:0] ret_byte = {DEV_ADDR_HI, strap_ff, lim_ff};

  // next-state logic of the whole engine
  always_comb begin
    nxt_scl_q = scl_i;
    nxt_sda_q = sda_i;
    nxt_st    = st_ff;
    nxt_sh    = sh_ff;
    nxt_bit   = bit_ff;
    nxt_sda   = sda_ff;
    nxt_alert = alert_ff;
    nxt_lim   = lim_ff;
    nxt_strap = strap_ff;
    nxt_tcnt  = tcnt_ff;
    nxt_ccnt  = ccnt_ff;
    nxt_busy  = busy_ff;
    nxt_cst   = 1'b0;
    nxt_tof   = 1'b0;
    nxt_ara   = ara_ff;
    // latched alarm event
    if (alarm_set && alert_en) begin
      nxt_alert = 1'b1;
      nxt_lim   = alarm_high;
    end
    if (!alert_en) begin
      nxt_alert = 1'b0;
    end
    // copy busy timer
    // bounded busy time
    if (busy_ff) begin
      if (ccnt_ff == COPY_CYCLES - 1) begin
        nxt_busy = 1'b0;
        nxt_ccnt = '0;
      end else begin
        nxt_ccnt = ccnt_ff + 32'h1;
      end
    end
    // serial state machine
    case (st_ff)
      SMBX_IDLE: begin
        nxt_sda = 1'b1;
      end
      SMBX_ADDR, SMBX_CMD: begin
        if (scl_rise) begin
          nxt_sh  = {sh_ff[6:0], sda_i};
          nxt_bit = bit_ff + 4'h1;
        end
        if (scl_fall && bit_ff == 4'h8) begin
          nxt_bit = '0;
          if (st_ff == SMBX_CMD) begin
            nxt_sda = 1'b0;
            nxt_st  = SMBX_CACK;
          end else if (sh_ff == ARA_BYTE && alert_ff && !alarm_set) begin
            nxt_sda = 1'b0;
            nxt_ara = 1'b1;
            nxt_st  = SMBX_AACK;
          end else if (sh_ff == {GCALL_ADDR, 1'b0}) begin
            nxt_sda = 1'b0;
            nxt_ara = 1'b0;
            nxt_st  = SMBX_AACK;
          end else begin
            nxt_st = SMBX_WAIT;
          end
        end
      end
      SMBX_AACK: begin
        if (scl_fall) begin
          if (ara_ff) begin
            nxt_sh  = ret_byte;
            nxt_sda = ret_byte[7];
            nxt_st  = SMBX_TXB;
          end else begin
            nxt_sda = 1'b1;
            nxt_st  = SMBX_CMD;
          end
        end
      end
      SMBX_TXB: begin
        if (scl_rise) begin
          if (sda_ff && !sda_i) begin
            nxt_sda = 1'b1;
            nxt_ara = 1'b0;
            nxt_st  = SMBX_WAIT;
          end else begin
            nxt_bit = bit_ff + 4'h1;
          end
        end
        if (scl_fall && st_ff == nxt_st) begin
          if (bit_ff == 4'h8) begin
            nxt_sda = 1'b1;
            nxt_bit = '0;
            nxt_st  = SMBX_TXACK;
          end else begin
            nxt_sh  = {sh_ff[6:0], 1'b0};
            nxt_sda = sh_ff[6];
          end
        end
      end
      SMBX_TXACK: begin
        if (scl_rise) begin
          nxt_alert = alarm_set & alert_en;
          nxt_ara   = 1'b0;
          nxt_st    = SMBX_WAIT;
        end
      end
      SMBX_CACK: begin
        if (scl_fall) begin
          nxt_sda = 1'b1;
          nxt_st  = SMBX_WAIT;
          if (sh_ff == GC_RELATCH) begin
            nxt_strap = addr_strap_pins;
          end else if (sh_ff == GC_RESET) begin
            nxt_strap = addr_strap_pins;
            nxt_busy  = 1'b1;
            nxt_ccnt  = '0;
            nxt_cst   = 1'b1;
          end
        end
      end
      SMBX_WAIT: begin
        nxt_sda = 1'b1;
      end
      default: begin
        nxt_st  = SMBX_IDLE;
        nxt_sda = 1'b1;
      end
    endcase
    // start and stop override the byte engine
    if (start_c) begin
      nxt_st  = SMBX_ADDR;
      nxt_bit = '0;
      nxt_sda = 1'b1;
      nxt_ara = 1'b0;
    end else if (stop_c) begin
      nxt_st  = SMBX_IDLE;
      nxt_sda = 1'b1;
      nxt_ara = 1'b0;
    end
    if (scl_i) begin
      nxt_tcnt = '0;
    end else if (tcnt_ff != TOUT_CYCLES) begin
      nxt_tcnt = tcnt_ff + 32'h1;
    end
    if (!scl_i && tcnt_ff == TOUT_CYCLES - 1) begin
      nxt_st  = SMBX_IDLE;
      nxt_sda = 1'b1;
      nxt_ara = 1'b0;
      nxt_bit = '0;
      nxt_tof = 1'b1;
    end
  end

  // register all engine state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      st_ff    <= SMBX_IDLE;
      sh_ff    <= '0;
      bit_ff   <= '0;
      sda_ff   <= 1'b1;
      alert_ff <= 1'b0;
      lim_ff   <= 1'b0;
      strap_ff <= STRAP_RST;
      tcnt_ff  <= '0;
      ccnt_ff  <= '0;
      busy_ff  <= 1'b0;
      cst_ff   <= 1'b0;
      tof_ff   <= 1'b0;
      ara_ff   <= 1'b0;
    end else begin
      scl_q_ff <= nxt_scl_q;
      sda_q_ff <= nxt_sda_q;
      st_ff    <= nxt_st;
      sh_ff    <= nxt_sh;
      bit_ff   <= nxt_bit;
      sda_ff   <= nxt_sda;
      alert_ff <= nxt_alert;
      lim_ff   <= nxt_lim;
      strap_ff <= nxt_strap;
      tcnt_ff  <= nxt_tcnt;
      ccnt_ff  <= nxt_ccnt;
      busy_ff  <= nxt_busy;
      cst_ff   <= nxt_cst;
      tof_ff   <= nxt_tof;
      ara_ff   <= nxt_ara;
    end
  end

  // outputs straight from flip-flops
  assign sda_oe_n    = sda_ff;
  assign alert_oe_n  = ~alert_ff;
  assign strap_addr  = strap_ff;
  assign copy_busy   = busy_ff;
  assign copy_start  = cst_ff;
  assign bus_timeout = tof_ff;

  // assertions
  // timeout releases data line
  property p_tout_release;
    @(posedge clk) disable iff (!rst_n) bus_timeout |-> sda_oe_n && st_ff == SMBX_IDLE;
  endproperty
  a_tout_release: assert property (p_tout_release) else $error("timeout did not release sda");
  // counter reaches threshold only while low
  property p_tout_cause;
    @(posedge clk) disable iff (!rst_n) $rose(bus_timeout) |-> $past(!scl_i);
  endproperty
  a_tout_cause: assert property (p_tout_cause) else $error("timeout without clock low");
  property p_alert_en;
    @(posedge clk) disable iff (!rst_n) !alert_oe_n |-> $past(alert_en);
  endproperty
  a_alert_en: assert property (p_alert_en) else $error("alert while disabled");
  // first returned bit is address msb one
  property p_ret_msb;
    @(posedge clk) disable iff (!rst_n) (st_ff == SMBX_AACK && nxt_st == SMBX_TXB) |=> sda_oe_n && sh_ff == ret_byte;
  endproperty
  a_ret_msb: assert property (p_ret_msb) else $error("wrong returned address");
  property p_ara_ack;
    @(posedge clk) disable iff (!rst_n) (st_ff == SMBX_AACK && ara_ff) |-> !alert_oe_n;
  endproperty
  a_ara_ack: assert property (p_ara_ack) else $error("ara ack without alert");
  property p_arb_lose;
    @(posedge clk) disable iff (!rst_n) (st_ff == SMBX_TXB && scl_rise && sda_ff && !sda_i && !start_c && !stop_c)
      |=> sda_oe_n && st_ff != SMBX_TXACK;
  endproperty
  a_arb_lose: assert property (p_arb_lose) else $error("kept driving after loss");
  property p_lose_alert;
    @(posedge clk) disable iff (!rst_n) (st_ff == SMBX_TXB && scl_rise && sda_ff && !sda_i && alert_en) |=> !alert_oe_n;
  endproperty
  a_lose_alert: assert property (p_lose_alert) else $error("loser dropped alert");
  property p_copy;
    @(posedge clk) disable iff (!rst_n) copy_start |-> copy_busy ##1 copy_busy;
  endproperty
  a_copy: assert property (p_copy) else $error("copy not busy");
  // busy bounded by power-on reset time
  property p_busy_len;
    @(posedge clk) disable iff (!rst_n) copy_busy |-> ccnt_ff < COPY_CYCLES && COPY_CYCLES <= TPOR_US * CLK_MHZ;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too long");
  // strap changes only at command ack
  property p_strap;
    @(posedge clk) disable iff (!rst_n) $changed(strap_addr) |-> $past(st_ff == SMBX_CACK);
  endproperty
  a_strap: assert property (p_strap) else $error("strap changed outside command");
endmodule : smbx_top

// [smbx_master.sv]
// Purpose: behavioural smbus master for the alert/timeout/general call block
// Assumes: sda is a wired-and with a pull-up, scl driven only here
// Notes:   one third of a bit lasts Q clock cycles; clock idles high between frames
`timescale 1ns/1ps
module smbx_master #(
  parameter int Q = 4 // cycles per third of a bit
) (
  input  wire logic clk,   // system clock
  input  wire logic sda,   // wired data level
  output logic      scl,   // bus clock drive
  output logic      sda_m  // data drive, one releases
);
  // both lines released at time zero
  initial {scl, sda_m} = 2'b11;
  // wait n edges, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic start();
    sda_m = 1'b1;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda_m = 1'b0;
    hold(Q);
    scl = 1'b0;
    hold(Q);
  endtask : start
  // data rises while clock high
  task automatic stop();
    sda_m = 1'b0;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda_m = 1'b1;
    hold(Q);
  endtask : stop
  task automatic bit1(input logic b, output logic r);
    sda_m = b;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    r = sda;
    scl = 1'b0;
    hold(Q);
  endtask : bit1
  // eight bits msb first, no ack slot
  task automatic byte8(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit1(w[i], r[i]);
    end
  endtask : byte8
endmodule : smbx_master

// [testbench.sv]
// Purpose: self-checking bench for alert response, timeout and general call
// Assumes: shortened timeout and copy counts
// Notes:   a competing slave is mimicked by other_sda
`timescale 1ns/1ps
module testbench;
  import smbx_pkg::*;
  localparam int TOUT = 50;          // short clock-low timeout
  localparam int COPY = 8;           // short copy time
  logic       clk;                   // system clock
  logic       rst_n;                 // reset, active low
  logic       other_sda;             // competing slave drive
  smbx_cfg_s  cfg;                   // irq mode, active low
  logic       alarm_set;             // limit pulse
  logic       alarm_high;            // high limit flag
  logic [2:0] straps;                // strap pin levels
  logic       scl, sda_m, sda, sda_oe_n, alert_oe_n, copy_busy, copy_start, bus_timeout;
  logic [2:0] strap_addr;            // latched strap
  int         err_count  = 0;        // mismatches
  int         n_checks   = 0;        // comparisons
  int         n_copy     = 0;        // copy start pulses
  int         n_busy     = 0;        // copy busy cycles
  int         n_tout     = 0;        // timeout pulses
  logic [7:0] rd;                    // returned byte
  logic       ak, ck;                // acknowledge bits
  // wired-and with pull-up
  assign sda = sda_m & sda_oe_n & other_sda;
  // free running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  smbx_top #(.TOUT_CYCLES(TOUT), .COPY_CYCLES(COPY)) u_smbx_top (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_oe_n(sda_oe_n), .alert_oe_n(alert_oe_n),
    .cfg(cfg), .alarm_set(alarm_set), .alarm_high(alarm_high), .addr_strap_pins(straps),
    .strap_addr(strap_addr), .copy_busy(copy_busy), .copy_start(copy_start), .bus_timeout(bus_timeout));
  smbx_master u_smbx_master (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  // count pulses and busy cycles
  always @(posedge clk) begin
    if (copy_start === 1'b1) n_copy <= n_copy + 1;
    if (copy_busy === 1'b1) n_busy <= n_busy + 1;
    if (bus_timeout === 1'b1) n_tout <= n_tout + 1;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // one-cycle limit event
  task automatic alarm(input logic hi);
    alarm_set = 1'b1;
    alarm_high = hi;
    u_smbx_master.hold(1);
    alarm_set = 1'b0;
    u_smbx_master.hold(3);
  endtask : alarm
  // alert response read, optional competitor pulling low
  task automatic ara(input logic comp, output logic a, output logic [7:0] b);
    logic [7:0] d;
    u_smbx_master.start();
    u_smbx_master.byte8(ARA_BYTE, d);
    u_smbx_master.bit1(1'b1, a);
    other_sda = ~comp;
    u_smbx_master.byte8(8'hff, b);
    other_sda = 1'b1;
    u_smbx_master.bit1(1'b0, d[0]);
    u_smbx_master.stop();
  endtask : ara
  // address byte then command byte
  task automatic gcall(input logic [7:0] adr, input logic [7:0] cmd, output logic a, output logic c);
    logic [7:0] d;
    u_smbx_master.start();
    u_smbx_master.byte8(adr, d);
    u_smbx_master.bit1(1'b1, a);
    u_smbx_master.byte8(cmd, d);
    u_smbx_master.bit1(1'b1, c);
    u_smbx_master.stop();
  endtask : gcall
  task automatic t_relatch();
    int c0;
    c0 = n_copy;
    straps = 3'h5;
    gcall(8'h00, GC_RELATCH, ak, ck);
    chk("gc ack", 8'h0, ak);
    chk("cmd ack", 8'h0, ck);
    chk("strap", 8'h5, strap_addr);
    chk("copy count", c0, n_copy);
  endtask : t_relatch
  task automatic t_reset();
    int c0, b0;
    c0 = n_copy;
    b0 = n_busy;
    straps = 3'h3;
    gcall(8'h00, GC_RESET, ak, ck);
    u_smbx_master.hold(COPY);
    chk("strap", 8'h3, strap_addr);
    chk("copy count", c0 + 1, n_copy);
    chk("busy cycles", COPY, n_busy - b0);
  endtask : t_reset
  task automatic t_other();
    int c0;
    c0 = n_copy;
    straps = 3'h6;
    for (int i = 0; i < 3; i++) begin
      gcall(8'h00, 8'h05 + 8'(i * 16), ak, ck);
      chk("cmd ack", 8'h0, ck);
    end
    gcall(8'h01, GC_RELATCH, ak, ck);
    chk("read nack", 8'h1, ak);
    chk("strap", 8'h3, strap_addr);
    chk("copy count", c0, n_copy);
  endtask : t_other
  task automatic t_alert();
    for (int i = 0; i < 2; i++) begin
      cfg = i[0] ? 2'b11 : 2'b00;
      alarm(1'b1);
      chk("alert off", 8'h1, alert_oe_n);
    end
    cfg = 2'b10;
    for (int i = 0; i < 2; i++) begin
      alarm(i[0]);
      chk("alert on", 8'h0, alert_oe_n);
      ara(1'b0, ak, rd);
      chk("ara ack", 8'h0, ak);
      chk("ara addr", {DEV_ADDR_HI, 3'h3, i[0]}, rd);
      chk("alert clear", 8'h1, alert_oe_n);
    end
    ara(1'b0, ak, rd);
    chk("idle ara nack", 8'h1, ak);
  endtask : t_alert
  task automatic t_arb();
    alarm(1'b1);
    ara(1'b1, ak, rd);
    chk("loser alert", 8'h0, alert_oe_n);
    chk("loser sda", 8'h1, sda_oe_n);
    ara(1'b0, ak, rd);
    chk("repeat addr", 8'h97, rd);
    chk("winner alert", 8'h1, alert_oe_n);
  endtask : t_arb
  task automatic t_timeout();
    logic [7:0] d;
    int t0;
    t0 = n_tout;
    u_smbx_master.start();
    u_smbx_master.byte8(8'h00, d);
    u_smbx_master.hold(2);
    chk("ack drive", 8'h0, sda_oe_n);
    u_smbx_master.hold(TOUT - 8);
    chk("early timeout", t0, n_tout);
    u_smbx_master.hold(10);
    chk("timeout", t0 + 1, n_tout);
    chk("sda release", 8'h1, sda_oe_n);
    alarm(1'b1);
    ara(1'b0, ak, rd);
    chk("ack after timeout", 8'h0, ak);
    chk("addr after timeout", 8'h97, rd);
  endtask : t_timeout
  // mid-run reset clears alert and strap
  task automatic t_rst();
    alarm(1'b0);
    rst_n = 1'b0;
    u_smbx_master.hold(2);
    rst_n = 1'b1;
    u_smbx_master.hold(2);
    chk("reset alert", 8'h1, alert_oe_n);
    chk("reset strap", 8'h0, strap_addr);
  endtask : t_rst
  // main sequence
  initial begin
    rst_n      = 1'b0;
    other_sda  = 1'b1;
    cfg        = 2'b10;
    alarm_set  = 1'b0;
    alarm_high = 1'b0;
    straps     = 3'h0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    u_smbx_master.hold(2);
    t_relatch();
    t_reset();
    t_other();
    t_alert();
    t_arb();
    t_timeout();
    t_rst();
    complete_run();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : testbench
